/* include/status_reg_pkg.sv */
// package: constants, carriers and states of the two-wire slave receiver end states
package status_reg_pkg;

  // ****************************************************************
  // status codes
  // ****************************************************************
  localparam logic [7:0] ST_START_SENT = 8'h08;
  localparam logic [7:0] ST_OWN_ACK    = 8'h60;
  localparam logic [7:0] ST_ARB_OWN    = 8'h68;
  localparam logic [7:0] ST_GC_ACK     = 8'h70;
  localparam logic [7:0] ST_ARB_GC     = 8'h78;
  localparam logic [7:0] ST_DATA_ACK   = 8'h80;
  localparam logic [7:0] ST_DATA_NACK  = 8'h88;
  localparam logic [7:0] ST_GC_DATA    = 8'h90;
  localparam logic [7:0] ST_GC_NACK    = 8'h98;
  localparam logic [7:0] ST_STOP_RX    = 8'ha0;
  localparam logic [7:0] ST_NO_INFO    = 8'hf8;

  // ****************************************************************
  // field layout and reset values
  // ****************************************************************
  localparam int         OWN_ADDR_LSB  = 1;
  localparam int         GCE_BIT       = 0;
  localparam logic [6:0] GC_ADDRESS    = 7'h00;
  localparam int         PRESC_LSB     = 0;
  localparam logic [7:0] DATA_RESET    = 8'h00;
  localparam logic       ACK_EN_RESET  = 1'b0;

  // ****************************************************************
  // timing, counted on the link clock
  // ****************************************************************
  localparam int         START_HOLD_NS  = 4000;
  localparam int         LINK_PERIOD_NS = 30;
  localparam logic [7:0] START_HOLD_CYC =
    8'((START_HOLD_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic step_clear;
    logic ack_enable;
    logic start_request;
    logic stop_request;
  } status_reg_ctrl_s;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] data;
  } status_reg_event_s;

  typedef struct packed {
    logic ack_enable;
    logic start_request;
  } status_reg_release_s;

  typedef enum logic [2:0] {
    LS_IDLE  = 3'b000,
    LS_ADDR  = 3'b001,
    LS_ACK   = 3'b010,
    LS_POST  = 3'b011,
    LS_HOLD  = 3'b100,
    LS_DATA  = 3'b101,
    LS_SKIP  = 3'b110,
    LS_START = 3'b111
  } status_reg_link_e;

endpackage

/* hw/status_reg_slave_rx.sv */
// two-wire slave receiver end states: link engine, crossings and software-side control
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - own-address data byte answered with not-acknowledge reports 0x88
// - general call data byte answered with acknowledge reports 0x90
// - general call data byte answered with not-acknowledge reports 0x98
// - after 0x90, clearing with ack enable 0 makes next byte not-acknowledged
// - after 0x90, clearing with ack enable 1 makes next byte acknowledged
// - stop or repeated start while addressed reports 0xa0
// - leaving 0x88/0x98/0xa0 with ack enable 0: recognise no address
// - same with ack enable 1: own address, general call only if enabled
// - start request on leaving those states sends start when bus free
// - own write reports 0x60, then 0x80 per acked byte, then 0xa0
// - addressed after lost arbitration reports 0x68, or 0x78 for general call
// - scl held low while the step flag is set, except after 0xa0; writing one clears it
// - own address sits in the upper seven bits, bit zero enables general call
module status_reg_slave_rx
  import status_reg_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        link_clk_in,
  input  wire logic        ctrl_write_in,
  input  wire status_reg_ctrl_s  ctrl_in,
  input  wire logic [7:0]  own_address_in,
  input  wire logic [1:0]  prescaler_in,
  input  wire logic        arb_lost_in,
  output logic             step_done_flag_out,
  output logic [7:0]       status_out,
  output logic [7:0]       data_out,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_out,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic          step_flag;
  logic [7:0]    status_code;
  logic [7:0]    data_q;
  logic [1:0]    presc_q;
  logic          ack_enable;
  logic [9:0]    cfg_core;
  logic          rel_tgl;
  status_reg_release_s rel_word;
  logic          ev_c1;
  logic          ev_c2;
  logic          ev_ack;
  status_reg_event_s   fifo_mem [2];
  logic          wr_ptr;
  logic          rd_ptr;
  logic [1:0]    fifo_cnt;
  logic          in_valid;
  logic          in_ready;
  logic          out_valid;
  logic          out_ready;
  logic          push;
  logic          pop;
  logic          clear_ok;

  logic [2:0]    scl_sync;
  logic [2:0]    sda_sync;
  logic [9:0]    cfg_l1;
  logic [9:0]    cfg_l2;
  logic          ack_l1;
  logic          ack_l2;
  logic          rel_l1;
  logic          rel_l2;
  logic          rel_done;
  logic          ev_tgl;
  status_reg_event_s   ev_word;
  status_reg_link_e    state;
  logic [3:0]    bit_cnt;
  logic [7:0]    shift;
  logic          addressed;
  logic          is_gc;
  logic          ack_next;
  logic [7:0]    post_code;
  logic          to_idle;
  logic          scl_drive;
  logic          sda_drive;
  logic          start_pend;
  logic          bus_busy;
  logic [7:0]    hold_cnt;

  logic          scl_rise;
  logic          scl_fall;
  logic          start_cond;
  logic          stop_cond;
  logic          ev_ready;
  logic          rel_valid;
  logic          ack_en_l;
  logic          gce_l;
  logic          arb_l;
  logic          own_hit;
  logic          gc_hit;
  logic          addr_match;
  logic          bus_event;
  logic          byte_end;

  // ****************************************************************
  // software side: step flag, status and data
  // ****************************************************************
  assign clear_ok  = ctrl_write_in && ctrl_in.step_clear && step_flag;
  assign out_valid = (fifo_cnt != 2'h0);
  assign out_ready = !step_flag;
  assign pop       = out_valid && out_ready;

  // load and clear never meet: a load needs the flag low, a clear needs it high
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      step_flag   <= 1'b0;
      status_code <= ST_NO_INFO;
      data_q      <= DATA_RESET;
    end else if (pop) begin
      step_flag   <= 1'b1;
      status_code <= fifo_mem[rd_ptr].code;
      data_q      <= fifo_mem[rd_ptr].data;
    end else if (clear_ok) begin
      step_flag   <= 1'b0;
      status_code <= ST_NO_INFO;
    end
  end

  // stop_request is ignored: software keeps it zero in these states
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_enable <= ACK_EN_RESET;
      rel_tgl    <= 1'b0;
      rel_word   <= '0;
      presc_q    <= 2'h0;
      cfg_core   <= 10'h000;
    end else begin
      presc_q  <= prescaler_in;
      cfg_core <= {ack_enable, arb_lost_in, own_address_in};
      if (ctrl_write_in) begin
        ack_enable <= ctrl_in.ack_enable;
      end
      if (clear_ok) begin
        rel_word <= '{ack_enable: ctrl_in.ack_enable,
                      start_request: ctrl_in.start_request};
        rel_tgl  <= ~rel_tgl;
      end
    end
  end

  assign step_done_flag_out = step_flag;
  assign status_out         = {status_code[7:2], presc_q};
  assign data_out           = data_q;

  // ****************************************************************
  // event crossing and two-entry buffer
  // ****************************************************************
  // the event word stays still until the link sees our acknowledge toggle
  assign in_valid = (ev_c2 != ev_ack);
  assign in_ready = (fifo_cnt != 2'h2);
  assign push     = in_valid && in_ready;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ev_c1  <= 1'b0;
      ev_c2  <= 1'b0;
      ev_ack <= 1'b0;
    end else begin
      ev_c1 <= ev_tgl;
      ev_c2 <= ev_c1;
      if (push) begin
        ev_ack <= ~ev_ack;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr      <= 1'b0;
      rd_ptr      <= 1'b0;
      fifo_cnt    <= 2'h0;
      fifo_mem[0] <= '0;
      fifo_mem[1] <= '0;
    end else begin
      if (push) begin
        fifo_mem[wr_ptr] <= ev_word;
        wr_ptr           <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      fifo_cnt <= 2'(fifo_cnt + {1'b0, push} - {1'b0, pop});
    end
  end

  // ****************************************************************
  // link side: pin and control crossings
  // ****************************************************************
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      cfg_l1   <= 10'h000;
      cfg_l2   <= 10'h000;
      ack_l1   <= 1'b0;
      ack_l2   <= 1'b0;
      rel_l1   <= 1'b0;
      rel_l2   <= 1'b0;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
      cfg_l1   <= cfg_core;
      cfg_l2   <= cfg_l1;
      ack_l1   <= ev_ack;
      ack_l2   <= ack_l1;
      rel_l1   <= rel_tgl;
      rel_l2   <= rel_l1;
    end
  end

  assign scl_rise   = scl_sync[1] && !scl_sync[2];
  assign scl_fall   = !scl_sync[1] && scl_sync[2];
  assign start_cond = scl_sync[1] && scl_sync[2] && sda_sync[2] && !sda_sync[1];
  assign stop_cond  = scl_sync[1] && scl_sync[2] && !sda_sync[2] && sda_sync[1];
  assign ev_ready   = (ack_l2 == ev_tgl);
  assign rel_valid  = (rel_l2 != rel_done);
  assign ack_en_l   = cfg_l2[9];
  assign arb_l      = cfg_l2[8];
  assign gce_l      = cfg_l2[GCE_BIT];
  assign own_hit    = (shift[7:1] == cfg_l2[OWN_ADDR_LSB +: 7]);
  assign gc_hit     = (shift[7:1] == GC_ADDRESS) && gce_l;
  // a read request is left to the transmitter logic and not answered here
  assign addr_match = ack_en_l && !shift[0] && (own_hit || gc_hit);
  assign byte_end   = scl_fall && (bit_cnt == 4'h8);
  assign bus_event  = (start_cond || stop_cond) &&
                      (state == LS_IDLE || state == LS_ADDR || state == LS_ACK ||
                       state == LS_DATA || state == LS_SKIP);

  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_busy <= 1'b0;
    end else if (start_cond) begin
      bus_busy <= 1'b1;
    end else if (stop_cond) begin
      bus_busy <= 1'b0;
    end
  end

  // ****************************************************************
  // link side: receive engine
  // ****************************************************************
  // limitation: an address sent right after 0xa0, before software clears, is missed
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state      <= LS_IDLE;
      bit_cnt    <= 4'h0;
      shift      <= 8'h00;
      addressed  <= 1'b0;
      is_gc      <= 1'b0;
      ack_next   <= 1'b0;
      post_code  <= ST_NO_INFO;
      to_idle    <= 1'b0;
      scl_drive  <= 1'b0;
      sda_drive  <= 1'b0;
      start_pend <= 1'b0;
      hold_cnt   <= 8'h00;
      ev_tgl     <= 1'b0;
      ev_word    <= '0;
      rel_done   <= 1'b0;
    end else if (bus_event) begin
      bit_cnt   <= 4'h0;
      sda_drive <= 1'b0;
      if (addressed) begin
        post_code <= ST_STOP_RX;
        to_idle   <= 1'b1;
        state     <= LS_POST;
      end else begin
        state <= start_cond ? LS_ADDR : LS_IDLE;
      end
    end else begin
      unique case (state)
        LS_IDLE: begin
          if (start_pend && !bus_busy) begin
            sda_drive <= 1'b1;
            hold_cnt  <= 8'h00;
            state     <= LS_START;
          end
        end
        LS_ADDR: begin
          if (scl_rise) begin
            shift   <= {shift[6:0], sda_sync[1]};
            bit_cnt <= 4'(bit_cnt + 4'h1);
          end else if (byte_end) begin
            if (addr_match) begin
              addressed <= 1'b1;
              is_gc     <= !own_hit;
              sda_drive <= 1'b1;
              to_idle   <= 1'b0;
              if (own_hit) begin
                post_code <= arb_l ? ST_ARB_OWN : ST_OWN_ACK;
              end else begin
                post_code <= arb_l ? ST_ARB_GC : ST_GC_ACK;
              end
              state <= LS_ACK;
            end else begin
              state <= LS_SKIP;
            end
          end
        end
        LS_DATA: begin
          if (scl_rise) begin
            shift   <= {shift[6:0], sda_sync[1]};
            bit_cnt <= 4'(bit_cnt + 4'h1);
          end else if (byte_end) begin
            sda_drive <= ack_next;
            to_idle   <= !ack_next;
            if (is_gc) begin
              post_code <= ack_next ? ST_GC_DATA : ST_GC_NACK;
            end else begin
              post_code <= ack_next ? ST_DATA_ACK : ST_DATA_NACK;
            end
            state <= LS_ACK;
          end
        end
        LS_ACK: begin
          if (scl_fall) begin
            sda_drive <= 1'b0;
            scl_drive <= 1'b1;
            bit_cnt   <= 4'h0;
            state     <= LS_POST;
          end
        end
        LS_POST: begin
          if (ev_ready) begin
            ev_word <= '{code: post_code, data: shift};
            ev_tgl  <= ~ev_tgl;
            state   <= LS_HOLD;
          end
        end
        LS_HOLD: begin
          if (rel_valid) begin
            rel_done   <= ~rel_done;
            ack_next   <= rel_word.ack_enable;
            start_pend <= rel_word.start_request;
            scl_drive  <= 1'b0;
            sda_drive  <= 1'b0;
            bit_cnt    <= 4'h0;
            if (to_idle) begin
              addressed <= 1'b0;
              state     <= LS_IDLE;
            end else begin
              state <= LS_DATA;
            end
          end
        end
        LS_SKIP: begin
          sda_drive <= 1'b0;
        end
        LS_START: begin
          hold_cnt <= 8'(hold_cnt + 8'h01);
          if (hold_cnt == START_HOLD_CYC - 8'h01) begin
            scl_drive  <= 1'b1;
            start_pend <= 1'b0;
            post_code  <= ST_START_SENT;
            to_idle    <= 1'b1;
            state      <= LS_POST;
          end
        end
      endcase
    end
  end

  assign scl_out    = 1'b0;
  assign sda_out    = 1'b0;
  assign scl_oe_out = scl_drive;
  assign sda_oe_out = sda_drive;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_nack_own_code: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    (state == LS_DATA && byte_end && !is_gc && !ack_next)
    |=> post_code == ST_DATA_NACK && !sda_drive && to_idle)
    else $error("own data nack not coded 0x88");

  chk_gc_ack_code: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    (state == LS_DATA && byte_end && is_gc && ack_next)
    |=> post_code == ST_GC_DATA && sda_drive)
    else $error("general call ack not coded 0x90");

  chk_gc_nack_code: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    (state == LS_DATA && byte_end && is_gc && !ack_next)
    |=> post_code == ST_GC_NACK && !sda_drive)
    else $error("general call nack not coded 0x98");

  chk_ack_from_rel: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    (state == LS_HOLD && rel_valid && !to_idle)
    |=> ack_next == $past(rel_word.ack_enable) && state == LS_DATA)
    else $error("next ack not taken from release");

  chk_stop_reports: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    (bus_event && addressed)
    |=> state == LS_POST && post_code == ST_STOP_RX && to_idle && !scl_drive)
    else $error("stop while addressed not coded 0xa0");

  chk_leave_idle: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    (state == LS_HOLD && rel_valid && to_idle)
    |=> state == LS_IDLE && !addressed && !scl_drive)
    else $error("end state not left to not-addressed");

  chk_no_ack_off: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    (state == LS_ADDR && byte_end && !ack_en_l) |=> state == LS_SKIP)
    else $error("address recognised with ack disabled");

  chk_gc_needs_gce: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    (state == LS_ADDR && byte_end && !own_hit && !gce_l) |=> state == LS_SKIP)
    else $error("general call recognised while disabled");

  chk_start_when_free: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    (state == LS_IDLE && start_pend && !bus_busy && !bus_event)
    |=> state == LS_START && sda_drive && !scl_drive)
    else $error("requested start not sent on free bus");

  chk_scl_stretch: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    (state == LS_HOLD && !rel_valid && scl_drive) |=> scl_drive)
    else $error("scl released before the flag was cleared");

  chk_own_code: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    (state == LS_ADDR && byte_end && addr_match && own_hit)
    |=> post_code == (arb_l ? ST_ARB_OWN : ST_OWN_ACK) && state == LS_ACK)
    else $error("own address code wrong");

  chk_flag_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    pop |=> step_flag && status_code == $past(fifo_mem[rd_ptr].code) ##1 step_flag || clear_ok)
    else $error("step flag not set with loaded status");

  chk_clear_rel: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    clear_ok |=> !step_flag && status_code == ST_NO_INFO && rel_tgl != $past(rel_tgl))
    else $error("clear did not release the link");

  cov_gc_byte: cover property (@(posedge link_clk_in) disable iff (!rst_n_in)
    state == LS_POST && post_code == ST_GC_DATA);
  cov_stop_seen: cover property (@(posedge link_clk_in) disable iff (!rst_n_in)
    state == LS_POST && post_code == ST_STOP_RX);
  cov_start_sent: cover property (@(posedge link_clk_in) disable iff (!rst_n_in)
    state == LS_START ##1 state == LS_START);
  cov_buffer_full: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    fifo_cnt == 2'h2);

endmodule

`default_nettype wire

/* test/status_reg_bus_master.sv */
// bus master model: open-drain pulls on the clock and data lines
`timescale 1ns/1ps
`default_nettype none
module status_reg_bus_master (
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_low_out,
  output logic      sda_low_out,
  output int        hang_out
);
  localparam int HALF_NS = 240;
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
    hang_out = 0;
  end
  // let the clock go and wait, bounded, while the slave stretches it
  task automatic rise();
    int n;
    n = 0;
    scl_low_out = 1'b0;
    while (scl_in !== 1'b1 && n < 400) begin
      #30;
      n++;
    end
    if (n >= 400) hang_out++;
    #HALF_NS;
  endtask
  // works from idle and as a repeated start from clock low
  task automatic start_c();
    sda_low_out = 1'b0;
    #HALF_NS;
    rise();
    sda_low_out = 1'b1;
    #HALF_NS;
    scl_low_out = 1'b1;
    #HALF_NS;
  endtask
  task automatic stop_c();
    sda_low_out = 1'b1;
    #HALF_NS;
    rise();
    sda_low_out = 1'b0;
    #HALF_NS;
  endtask
  // eight bits msb first, then the answer bit (0 = ack)
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low_out = ~b[i];
      #HALF_NS;
      rise();
      scl_low_out = 1'b1;
    end
    sda_low_out = 1'b0;
    #HALF_NS;
    rise();
    ack = sda_in;
    scl_low_out = 1'b1;
    #HALF_NS;
  endtask
endmodule
`default_nettype wire

/* test/tb_status_reg_slave_rx.sv */
// self-checking bench for the two-wire slave receiver end states
`timescale 1ns/1ps
`default_nettype none
module tb_status_reg_slave_rx
  import status_reg_pkg::*;
;
  logic        clk_in, link_clk_in, rst_n_in, ctrl_write_in, arb_lost_in;
  status_reg_ctrl_s  ctrl_in;
  logic [7:0]  own_address_in, status_out, data_out;
  logic [1:0]  prescaler_in;
  logic        step_done_flag_out, scl_out, scl_oe_out, sda_out, sda_oe_out;
  logic        scl_w, sda_w, scl_low, sda_low, ack;
  logic [6:0]  own;
  logic [31:0] seed = 32'h73c65608;
  int          n_fail, n_compared, hang, n_starts, s0;
  logic [7:0]  exp_q[$];
  assign scl_w = (scl_oe_out ? scl_out : 1'b1) & ~scl_low;
  assign sda_w = (sda_oe_out ? sda_out : 1'b1) & ~sda_low;
  always @(negedge sda_w) if (scl_w === 1'b1) n_starts++;
  status_reg_slave_rx dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk_in),
    .ctrl_write_in(ctrl_write_in), .ctrl_in(ctrl_in), .own_address_in(own_address_in),
    .prescaler_in(prescaler_in), .arb_lost_in(arb_lost_in),
    .step_done_flag_out(step_done_flag_out), .status_out(status_out), .data_out(data_out),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe_out(sda_oe_out));
  status_reg_bus_master m (.scl_in(scl_w), .sda_in(sda_w), .scl_low_out(scl_low),
    .sda_low_out(sda_low), .hang_out(hang));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // link clock offset so its edges never line up with the core clock
  initial begin
    link_clk_in = 1'b0;
    #7.3;
    forever #15 link_clk_in = ~link_clk_in;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string name, input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, e, s);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic ctl(input logic a, input logic st, input logic clr);
    @(negedge clk_in);
    ctrl_write_in = 1'b1;
    ctrl_in = '{step_clear: clr, ack_enable: a, start_request: st, stop_request: 1'b0};
    @(negedge clk_in);
    ctrl_write_in = 1'b0;
  endtask
  task automatic cfg(input logic g, input logic a);
    @(negedge clk_in);
    own_address_in[GCE_BIT] = g;
    arb_lost_in = a;
  endtask
  // data is read out before any clear is issued
  task automatic ev(input logic [7:0] code);
    int n;
    n = 0;
    while (step_done_flag_out !== 1'b1 && n < 8000) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 8000) begin
      n_fail++;
      wrap_up();
    end
    check("code", status_out & 8'hfc, code);
    check("prescaler", {6'h00, status_out[1:0]}, {6'h00, prescaler_in});
    if (exp_q.size() > 0) check("data", data_out, exp_q.pop_front());
    check("scl held", {7'h00, scl_oe_out}, {7'h00, code != ST_STOP_RX});
  endtask
  task automatic no_ev();
    repeat (3000) @(negedge clk_in);
    check("quiet", {7'h00, step_done_flag_out}, 8'h00);
  endtask
  task automatic adr(input logic [6:0] a, input logic nack, input logic [7:0] code);
    m.start_c();
    m.send({a, 1'b0}, ack);
    check("addr ack", {7'h00, ack}, {7'h00, nack});
    if (!nack) ev(code);
  endtask
  task automatic byt(input logic nack, input logic [7:0] code);
    logic [7:0] b;
    b = 8'(rnd());
    exp_q.push_back(b);
    m.send(b, ack);
    check("data ack", {7'h00, ack}, {7'h00, nack});
    ev(code);
  endtask
  initial begin
    rst_n_in = 1'b0;
    ctrl_write_in = 1'b0;
    ctrl_in = '0;
    arb_lost_in = 1'b0;
    own = 7'(rnd()) | 7'h01;
    own_address_in = {own, 1'b0};
    prescaler_in = 2'(rnd());
    repeat (20) @(negedge clk_in);
    check("flag", {7'h00, step_done_flag_out}, 8'h00);
    check("status", status_out, ST_NO_INFO);
    check("data", data_out, DATA_RESET);
    rst_n_in = 1'b1;
    repeat (10) @(negedge clk_in);
    ctl(1'b1, 1'b0, 1'b0);
    adr(own, 1'b0, ST_OWN_ACK);
    ctl(1'b1, 1'b0, 1'b1);
    byt(1'b0, ST_DATA_ACK);
    ctl(1'b0, 1'b0, 1'b1);
    byt(1'b1, ST_DATA_NACK);
    ctl(1'b0, 1'b0, 1'b1);
    m.stop_c();
    no_ev();
    adr(own, 1'b1, ST_OWN_ACK);
    m.stop_c();
    cfg(1'b1, 1'b0);
    ctl(1'b1, 1'b0, 1'b0);
    adr(GC_ADDRESS, 1'b0, ST_GC_ACK);
    ctl(1'b1, 1'b0, 1'b1);
    byt(1'b0, ST_GC_DATA);
    ctl(1'b1, 1'b0, 1'b1);
    byt(1'b0, ST_GC_DATA);
    ctl(1'b0, 1'b0, 1'b1);
    byt(1'b1, ST_GC_NACK);
    ctl(1'b1, 1'b0, 1'b1);
    m.stop_c();
    adr(own, 1'b0, ST_OWN_ACK);
    ctl(1'b1, 1'b0, 1'b1);
    m.stop_c();
    ev(ST_STOP_RX);
    cfg(1'b0, 1'b0);
    ctl(1'b1, 1'b0, 1'b1);
    adr(GC_ADDRESS, 1'b1, ST_GC_ACK);
    m.stop_c();
    cfg(1'b1, 1'b1);
    adr(own, 1'b0, ST_ARB_OWN);
    ctl(1'b1, 1'b0, 1'b1);
    m.stop_c();
    ev(ST_STOP_RX);
    ctl(1'b1, 1'b0, 1'b1);
    adr(GC_ADDRESS, 1'b0, ST_ARB_GC);
    ctl(1'b1, 1'b0, 1'b1);
    m.stop_c();
    ev(ST_STOP_RX);
    s0 = n_starts;
    ctl(1'b1, 1'b1, 1'b1);
    ev(ST_START_SENT);
    check("starts", 8'(n_starts - s0), 8'h01);
    ctl(1'b1, 1'b0, 1'b1);
    repeat (100) @(negedge clk_in);
    check("released", {6'h00, scl_oe_out, sda_oe_out}, 8'h00);
    check("hang", 8'(hang), 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
